/* ebm_params.svh */
`ifndef EBM_PARAMS_SVH
`define EBM_PARAMS_SVH
`define EBM_OFS_CFG 8'h00
`define EBM_OFS_STATUS 8'h04
`define EBM_OFS_TRAPADR 8'h08
`define EBM_SEGDIS_BIT 11
`define EBM_ACTIVE_BIT 10
`define EBM_BHDIS_BIT 9
`define EBM_TYPE_HI 7
`define EBM_TYPE_LO 6
`define EBM_WAIT_HI 3
`define EBM_WAIT_LO 0
`define EBM_WAIT_SLOW 4'hf
`define EBM_CFG_MASK 16'h0ecf
`define EBM_FIX_BASE 16'hfa00
`define EBM_ROM_SEG0 3'h0
`define EBM_ROM_SEG1 3'h2
`define EBM_RST_VEC 18'h00000
`define EBM_PIN_SINGLE 3'h4
`endif

/* ebm_pkg.sv */
package ebm_pkg;
  typedef enum logic [2:0] {
    MD_SINGLE = 3'b000,
    MD_8NM    = 3'b001,
    MD_8M     = 3'b010,
    MD_16M    = 3'b011,
    MD_16NM   = 3'b100
  } ebm_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10
  } ebm_st_t;
  typedef struct packed {
    logic        valid;
    logic [17:0] addr;
    logic        word;
    logic        write;
    logic [15:0] wdata;
  } ebm_req_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ebm_apb_t;
  typedef struct packed {
    logic [15:0] p0_out;
    logic [1:0]  p0_oe;
    logic [15:0] p1_out;
    logic        p1_oe;
    logic [1:0]  p4_out;
    logic        p4_oe;
    logic        ale;
    logic        rd_n;
    logic        wr_n;
    logic        byte_high_enable_n;
    logic        byte_high_oe;
  } ebm_pins_t;
endpackage : ebm_pkg

/* ebm_top.sv */
// How it works
// - reset samples three config pins into register
// - pin codes pick single chip or bus
// - active bit set: type picks bus mode
// - active clear during init: type sets rom
// - after end of init rom setup locked
// - 8-bit mux: address/data on port0 low
// - 16-bit mux: address/data on full port0
// - non-mux: address port1, data port0
// - port4 upper address until segmentation disabled
// - byte high enable if 16-bit at reset
// - 0fa00h to 0ffffh always internal
// - single chip pin code 100 only: low 32k internal rom
// - 08000h-0f9ffh external; other segments external unless rom moved to 10000h-17fffh
// - no external above 0ffffh unsegmented/single
// - reset clears instruction and segment pointers
// - single chip external access traps
// - single chip leaves ports 0,1,4 free
// - software may leave single chip mode
// - reset sets slowest bus timing
// - 8-bit word split low byte first
// - byte high enable and a0 select lanes
`timescale 1ns/100ps
`include "ebm_params.svh"
module ebm_top (
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              BUS_CFG_PIN_LO,
  input  wire logic              BUS_CFG_PIN_HI,
  input  wire logic              BUS_ACTIVE_SELECT,
  input  wire logic              END_OF_INIT,
  input  wire ebm_pkg::ebm_req_t REQ,
  input  wire logic [15:0]       P0_IN,
  input  wire ebm_pkg::ebm_apb_t APB,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  output ebm_pkg::ebm_pins_t     PINS,
  output logic                   ACC_DONE,
  output logic                   ACC_INTERNAL,
  output logic                   ACC_TRAP,
  output logic [15:0]            RDATA,
  output logic                   BOOT_INTERNAL,
  output logic [17:0]            BOOT_VECTOR
);
  import ebm_pkg::*;

  typedef struct packed {
    logic [2:0]  cfg_s1;
    logic [2:0]  cfg_s2;
    logic [15:0] p0_s1;
    logic [15:0] p0_s2;
    logic [15:0] cfg;
    logic        init_done;
    logic        rom_en;
    logic        rom_seg1;
    logic        ext_off;
    logic        rst16;
    logic        boot_internal;
    logic [17:0] boot_vec;
    ebm_st_t     st;
    logic [3:0]  waitcnt;
    logic        second;
    ebm_req_t    cur;
    ebm_pins_t   pins;
    logic        done;
    logic        internal;
    logic        trap;
    logic [15:0] rdata;
    logic [17:0] trap_addr;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ebm_regs_t;

  ebm_regs_t r;
  ebm_regs_t n;
  ebm_mode_t m;
  ebm_mode_t nm;
  logic      eight;
  logic      mux;
  logic      fixed_hit;
  logic      rom_hit;
  logic [7:0] wbyte;

  function automatic ebm_mode_t mode_of(input logic [15:0] c);
    if (!c[`EBM_ACTIVE_BIT]) begin
      mode_of = MD_SINGLE;
    end else begin
      case (c[`EBM_TYPE_HI:`EBM_TYPE_LO])
        2'b00:   mode_of = MD_8NM;
        2'b01:   mode_of = MD_8M;
        2'b10:   mode_of = MD_16M;
        default: mode_of = MD_16NM;
      endcase
    end
  endfunction : mode_of

  always_comb begin
    n = r;
    m = mode_of(r.cfg);
    n.cfg_s1 = {BUS_ACTIVE_SELECT, BUS_CFG_PIN_HI, BUS_CFG_PIN_LO};
    n.cfg_s2 = r.cfg_s1;
    n.p0_s1 = P0_IN;
    n.p0_s2 = r.p0_s1;
    n.done = 1'b0;
    n.internal = 1'b0;
    n.trap = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;

    // read data and error are settled in setup so they stand with pready
    if (APB.psel && !APB.penable) begin
      n.pready = 1'b1;
      n.prdata = 32'h0;
      case (APB.paddr)
        `EBM_OFS_CFG: begin
          n.prdata = {16'h0, r.cfg};
        end
        `EBM_OFS_STATUS: begin
          n.prdata = {23'h0, r.init_done, r.rom_en, r.rom_seg1, r.ext_off, m, r.st};
          n.pslverr = APB.pwrite;
        end
        `EBM_OFS_TRAPADR: begin
          n.prdata = {14'h0, r.trap_addr};
          n.pslverr = APB.pwrite;
        end
        default: begin
          n.pslverr = 1'b1;
        end
      endcase
    end
    if (APB.psel && APB.penable && r.pready && APB.pwrite && APB.paddr == `EBM_OFS_CFG) begin
      n.cfg = APB.pwdata[15:0] & `EBM_CFG_MASK;
      if (!r.init_done && !APB.pwdata[`EBM_ACTIVE_BIT]) begin
        case (APB.pwdata[`EBM_TYPE_HI:`EBM_TYPE_LO])
          2'b00: begin
            n.rom_en = 1'b1;
            n.rom_seg1 = 1'b0;
          end
          2'b01: begin
            n.rom_en = 1'b1;
            n.rom_seg1 = 1'b1;
          end
          2'b10: begin
            n.rom_en = 1'b0;
          end
          default: begin
            n.ext_off = 1'b1;
          end
        endcase
      end
    end
    if (END_OF_INIT) begin
      n.init_done = 1'b1;
    end

    fixed_hit = REQ.addr[17:16] == 2'b00 && REQ.addr[15:0] >= `EBM_FIX_BASE;
    rom_hit = r.rom_en && REQ.addr[17:15] == (r.rom_seg1 ? `EBM_ROM_SEG1 : `EBM_ROM_SEG0);
    eight = m == MD_8NM || m == MD_8M;
    case (r.st)
      ST_IDLE: begin
        if (REQ.valid && !r.done) begin
          n.cur = REQ;
          n.second = 1'b0;
          if (fixed_hit) begin
            n.internal = 1'b1;
            n.done = 1'b1;
          end else if (rom_hit) begin
            n.internal = 1'b1;
            n.done = 1'b1;
          end else if (m == MD_SINGLE || (r.cfg[`EBM_SEGDIS_BIT] && REQ.addr[17:16] != 2'b00)) begin
            n.trap = 1'b1;
            n.done = 1'b1;
            n.trap_addr = REQ.addr;
          end else begin
            n.st = ST_ADDR;
          end
        end
      end
      ST_ADDR: begin
        n.st = ST_DATA;
        n.waitcnt = r.cfg[`EBM_WAIT_HI:`EBM_WAIT_LO];
      end
      ST_DATA: begin
        if (r.waitcnt != 4'h0) begin
          n.waitcnt = r.waitcnt - 4'h1;
        end else begin
          if (!eight) begin
            n.rdata = r.p0_s2;
          end else if (r.second) begin
            n.rdata[15:8] = r.p0_s2[7:0];
          end else begin
            n.rdata = {8'h00, r.p0_s2[7:0]};
          end
          if (eight && r.cur.word && !r.second) begin
            n.second = 1'b1;
            n.cur.addr = r.cur.addr + 18'h1;
            n.st = ST_ADDR;
          end else begin
            n.st = ST_IDLE;
            n.done = 1'b1;
          end
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    if (RST) begin
      // syncs keep running so the last reset cycle sees settled pins
      n.cfg = 16'h0;
      n.cfg[`EBM_ACTIVE_BIT] = !r.cfg_s2[2];
      n.cfg[`EBM_TYPE_HI:`EBM_TYPE_LO] = r.cfg_s2[1:0];
      n.cfg[`EBM_WAIT_HI:`EBM_WAIT_LO] = `EBM_WAIT_SLOW;
      n.rom_en = r.cfg_s2 == `EBM_PIN_SINGLE;
      n.rom_seg1 = 1'b0;
      n.ext_off = r.cfg_s2[2];
      n.rst16 = !r.cfg_s2[2] && r.cfg_s2[1];
      n.boot_internal = r.cfg_s2 == `EBM_PIN_SINGLE;
      n.boot_vec = `EBM_RST_VEC;
      n.init_done = 1'b0;
      n.st = ST_IDLE;
      n.waitcnt = 4'h0;
      n.second = 1'b0;
      n.cur = '0;
      n.done = 1'b0;
      n.internal = 1'b0;
      n.trap = 1'b0;
      n.rdata = 16'h0;
      n.trap_addr = 18'h0;
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      n.prdata = 32'h0;
    end

    // pins follow the next state so every pin leaves a flip-flop
    nm = mode_of(n.cfg);
    mux = nm == MD_8M || nm == MD_16M;
    wbyte = (n.cur.word && n.cur.addr[0]) ? n.cur.wdata[15:8] : n.cur.wdata[7:0];
    n.pins = '0;
    n.pins.rd_n = 1'b1;
    n.pins.wr_n = 1'b1;
    n.pins.byte_high_enable_n = 1'b1;
    if (nm != MD_SINGLE) begin
      n.pins.p4_oe = !n.cfg[`EBM_SEGDIS_BIT];
      n.pins.p4_out = n.cur.addr[17:16];
      if (!mux) begin
        n.pins.p1_oe = 1'b1;
        n.pins.p1_out = n.cur.addr[15:0];
      end
      if (n.st == ST_ADDR) begin
        n.pins.ale = 1'b1;
        if (nm == MD_8M) begin
          n.pins.p0_out = {8'h00, n.cur.addr[7:0]};
          n.pins.p0_oe = 2'b01;
        end else if (nm == MD_16M) begin
          n.pins.p0_out = n.cur.addr[15:0];
          n.pins.p0_oe = 2'b11;
        end
      end
      if (n.st == ST_DATA) begin
        n.pins.rd_n = n.cur.write;
        n.pins.wr_n = !n.cur.write;
        if (n.cur.write) begin
          if (nm == MD_8M || nm == MD_8NM) begin
            n.pins.p0_out = {8'h00, wbyte};
            n.pins.p0_oe = 2'b01;
          end else begin
            // a byte goes on both lanes; the enables pick the memory
            n.pins.p0_out = n.cur.word ? n.cur.wdata : {wbyte, wbyte};
            n.pins.p0_oe = 2'b11;
          end
        end
      end
      n.pins.byte_high_oe = n.rst16 && !n.cfg[`EBM_BHDIS_BIT] && !(nm == MD_8M || nm == MD_8NM);
      if (n.pins.byte_high_oe && n.st != ST_IDLE) begin
        n.pins.byte_high_enable_n = !(n.cur.word || n.cur.addr[0]);
      end
    end
  end

  always_ff @(posedge CLK) begin
    r <= n;
  end

  assign PRDATA = r.prdata;
  assign PREADY = r.pready;
  assign PSLVERR = r.pslverr;
  assign PINS = r.pins;
  assign ACC_DONE = r.done;
  assign ACC_INTERNAL = r.internal;
  assign ACC_TRAP = r.trap;
  assign RDATA = r.rdata;
  assign BOOT_INTERNAL = r.boot_internal;
  assign BOOT_VECTOR = r.boot_vec;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  cfg_capture_a: assert property ($fell(RST) |->
    r.cfg[`EBM_ACTIVE_BIT] == !$past(r.cfg_s2[2])
    && r.cfg[`EBM_TYPE_HI:`EBM_TYPE_LO] == $past(r.cfg_s2[1:0]))
    else $error("config pins not captured at reset");

  slow_timing_a: assert property ($fell(RST) |->
    r.cfg[`EBM_WAIT_HI:`EBM_WAIT_LO] == `EBM_WAIT_SLOW)
    else $error("timing not slowest after reset");

  rom_lock_a: assert property (r.init_done |=>
    $stable(r.rom_en) && $stable(r.rom_seg1) && $stable(r.ext_off))
    else $error("rom setup changed after end of init");

  fixed_internal_a: assert property (
    r.st == ST_IDLE && REQ.valid && !r.done && fixed_hit |=> ACC_INTERNAL && ACC_DONE)
    else $error("fixed area not served internally");

  single_trap_a: assert property (
    r.st == ST_IDLE && REQ.valid && !r.done && !fixed_hit && !rom_hit
    && mode_of(r.cfg) == MD_SINGLE |=> ACC_TRAP && r.st == ST_IDLE)
    else $error("single chip access not trapped");

  single_ports_a: assert property (mode_of(r.cfg) == MD_SINGLE |->
    PINS.p0_oe == 2'b00 && !PINS.p1_oe && !PINS.p4_oe && !PINS.ale)
    else $error("port driven in single chip mode");

  upper_addr_a: assert property (PINS.p4_oe |->
    mode_of(r.cfg) != MD_SINGLE && !r.cfg[`EBM_SEGDIS_BIT])
    else $error("upper address driven while disabled");

  split_word_a: assert property (
    PINS.ale && !r.second && r.cur.word && (mode_of(r.cfg) == MD_8M
    || mode_of(r.cfg) == MD_8NM) |-> ##[2:40] (PINS.ale && r.second && r.cur.addr[0]))
    else $error("8-bit word not split into two bytes");

  byte_lane_a: assert property (
    PINS.byte_high_oe && r.st != ST_IDLE && !r.cur.addr[0] && !r.cur.word
    |-> PINS.byte_high_enable_n)
    else $error("low byte access enabled high byte");

  apb_ready_a: assert property (APB.psel && !APB.penable |=> PREADY ##1 !PREADY)
    else $error("apb ready not one cycle after setup");
endmodule : ebm_top

/* ebm_mem.sv */
`timescale 1ns/100ps
module ebm_mem (
  input  wire logic               CLK,
  input  wire ebm_pkg::ebm_pins_t PINS,
  output logic [15:0]             P0_IN
);
  import ebm_pkg::*;
  logic [7:0]  mem [0:65535];
  logic [15:0] adr;
  logic [15:0] last;
  // upper address bits ignored: tests keep segments apart by low address
  always @(posedge CLK) begin
    last <= P0_IN;
    if (PINS.ale) begin
      adr <= PINS.p1_oe ? PINS.p1_out : PINS.p0_out;
    end
    if (!PINS.wr_n) begin
      // a wide bus with no byte enable stores both lanes
      if (PINS.p0_oe[1] && (!PINS.byte_high_oe || !PINS.byte_high_enable_n)) begin
        mem[adr | 16'h0001] <= PINS.p0_out[15:8];
      end
      if (!PINS.p0_oe[1] || !PINS.byte_high_oe || !adr[0]) begin
        mem[adr] <= PINS.p0_out[7:0];
      end
    end
  end
  // released bus shows a changing pattern, not a stale copy
  assign P0_IN = PINS.rd_n ? ~last :
                 {mem[adr | 16'h0001], PINS.byte_high_oe ? mem[adr & 16'hfffe] : mem[adr]};
endmodule : ebm_mem

/* ebm_top_tb.sv */
`timescale 1ns/100ps
module ebm_top_tb;
  import ebm_pkg::*;
  localparam logic [18:0] E_INT = 19'h40000;
  localparam logic [18:0] E_TRAP = 19'h20000;
  localparam logic [18:0] E_EXT = 19'h00000;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        lo = 1'b0;
  logic        hi = 1'b0;
  logic        act = 1'b1;
  logic        eoi = 1'b0;
  ebm_req_t    req = '0;
  ebm_apb_t    apb = '0;
  ebm_pins_t   pins;
  logic [15:0] p0_in, rdata, w;
  logic [15:0] seed = 16'hd168;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, done, a_int, a_trap, boot, err;
  logic [17:0] bvec, a;
  logic [18:0] exp_q [$];
  logic [18:0] e;
  int          err_count = 0;
  int          checks = 0;
  int          i;

  ebm_top i_ebm_top (.CLK(clk), .RST(rst), .BUS_CFG_PIN_LO(lo), .BUS_CFG_PIN_HI(hi),
    .BUS_ACTIVE_SELECT(act), .END_OF_INIT(eoi), .REQ(req), .P0_IN(p0_in), .APB(apb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PINS(pins), .ACC_DONE(done),
    .ACC_INTERNAL(a_int), .ACC_TRAP(a_trap), .RDATA(rdata), .BOOT_INTERNAL(boot),
    .BOOT_VECTOR(bvec));
  ebm_mem i_ebm_mem (.CLK(clk), .PINS(pins), .P0_IN(p0_in));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  function automatic logic [15:0] nxt();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction : nxt

  task automatic do_reset(input logic b, input logic [1:0] c);
    @(posedge clk);
    rst <= 1'b1;
    act <= b;
    {hi, lo} <= c;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : do_reset

  task automatic apb_rw(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk);
    apb <= '{1'b1, 1'b0, wr, ad, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    check(pready, 1'b1);
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask : apb_rw

  task automatic acc(input logic [17:0] ad, input logic wd, input logic wr,
                     input logic [15:0] d, input logic [18:0] ex);
    int n;
    @(posedge clk);
    exp_q.push_back(ex);
    req <= '{1'b1, ad, wd, wr, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 100);
    check(done, 1'b1);
    req.valid <= 1'b0;
  endtask : acc

  always @(posedge clk) begin
    if (done === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check({a_int, a_trap}, e[18:17]);
      if (e[16]) check(rdata, e[15:0]);
    end
  end

  initial begin
    #200000;
    err_count++;
    complete_run();
  end

  initial begin
    for (i = 0; i < 8; i++) begin
      do_reset(i[2], i[1:0]);
      apb_rw(1'b0, 8'h00, 32'h0);
      check(rd, {21'h0, ~i[2], 2'b00, i[1:0], 6'h0f});
      check(boot, i[2:0] == 3'b100);
    end
    do_reset(1'b1, 2'b00);
    check({boot, bvec}, 19'h40000);
    check({pins.p0_oe, pins.p1_oe, pins.p4_oe}, 4'h0);
    acc(18'h00100, 1'b1, 1'b0, 16'h0, E_INT);
    acc(18'h0fa02, 1'b1, 1'b0, 16'h0, E_INT);
    acc(18'h08000, 1'b1, 1'b0, 16'h0, E_TRAP);
    acc(18'h10000, 1'b1, 1'b0, 16'h0, E_TRAP);
    apb_rw(1'b0, 8'h0c, 32'h0);
    check(err, 1'b1);
    apb_rw(1'b1, 8'h00, 32'h0040);
    acc(18'h10100, 1'b1, 1'b0, 16'h0, E_INT);
    acc(18'h00100, 1'b1, 1'b0, 16'h0, E_TRAP);
    apb_rw(1'b1, 8'h00, 32'h0000);
    apb_rw(1'b1, 8'h00, 32'h04c2);
    acc(18'h08000, 1'b1, 1'b1, 16'h1234, E_EXT);
    acc(18'h08000, 1'b1, 1'b0, 16'h0, {3'b001, 16'h1234});
    acc(18'h00100, 1'b1, 1'b0, 16'h0, E_INT);
    do_reset(1'b0, 2'b11);
    check({boot, pins.p4_oe, pins.byte_high_oe}, 3'b011);
    apb_rw(1'b1, 8'h00, 32'h04c2);
    for (i = 0; i < 5; i++) begin
      w = nxt();
      a = 18'h08000 + 18'(i * 2);
      acc(a, 1'b1, 1'b1, w, E_EXT);
      acc(a, 1'b1, 1'b0, 16'h0, {3'b001, w});
    end
    acc(18'h08009, 1'b0, 1'b1, 16'h00a5, E_EXT);
    acc(18'h08008, 1'b1, 1'b0, 16'h0, {3'b001, 8'ha5, w[7:0]});
    acc(18'h00100, 1'b1, 1'b1, w, E_EXT);
    acc(18'h10004, 1'b1, 1'b1, w, E_EXT);
    @(posedge clk);
    eoi <= 1'b1;
    @(posedge clk);
    eoi <= 1'b0;
    apb_rw(1'b1, 8'h00, 32'h0000);
    acc(18'h00100, 1'b1, 1'b0, 16'h0, E_TRAP);
    apb_rw(1'b1, 8'h00, 32'h0442);
    apb_rw(1'b0, 8'h04, 32'h0);
    check({rd[8], rd[4:2]}, 4'ha);
    w = nxt();
    acc(18'h09000, 1'b1, 1'b1, w, E_EXT);
    acc(18'h09000, 1'b1, 1'b0, 16'h0, {3'b001, w});
    check(pins.byte_high_oe, 1'b0);
    apb_rw(1'b1, 8'h00, 32'h0482);
    acc(18'h09100, 1'b1, 1'b1, ~w, E_EXT);
    acc(18'h09100, 1'b1, 1'b0, 16'h0, {3'b001, ~w});
    apb_rw(1'b1, 8'h00, 32'h0c82);
    acc(18'h10000, 1'b1, 1'b0, 16'h0, E_TRAP);
    check(pins.p4_oe, 1'b0);
    apb_rw(1'b1, 8'h00, 32'h0e82);
    @(posedge clk);
    check(pins.byte_high_oe, 1'b0);
    complete_run();
  end
endmodule : ebm_top_tb
